// ==== logic/amgp_pkg.sv ====
package amgp_pkg;

  // Port width and APB address width
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned PADDR_W = 18;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_PULLUP = 16'hFFAC;
  localparam logic [15:0] IDX_DIR    = 16'hFFB0;
  localparam logic [15:0] IDX_DATA   = 16'hFFB2;

  // Reset and forced values
  localparam logic [7:0] RST_DIR    = 8'h00;
  localparam logic [7:0] DIR_MODE1  = 8'hFF;
  localparam logic [7:0] DIR_READ   = 8'hFF;
  localparam logic [7:0] RST_DATA   = 8'h00;
  localparam logic [7:0] RST_PULLUP = 8'h00;
  localparam logic [7:0] PIN_IDLE   = 8'h00;

  // Upper read-data bits above the port width
  localparam logic [23:0] RD_PAD = 24'h000000;

  // Operating mode as presented on the mode pins
  typedef enum logic [1:0] {
    MODE_NONE = 2'h0,
    MODE_1    = 2'h1,
    MODE_2    = 2'h2,
    MODE_3    = 2'h3
  } amgp_mode_t;

  // Function of one pin, Gray ordered
  typedef enum logic [1:0] {
    ROLE_IN   = 2'h0,
    ROLE_ADDR = 2'h1,
    ROLE_GPO  = 2'h3,
    ROLE_PAT  = 2'h2
  } amgp_role_t;

endpackage

// ==== logic/amgp_sync.sv ====
`timescale 1ns/1ps

// Three-stage input synchroniser with agreement filter
module amgp_sync #(
  parameter int unsigned W       = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] s1_reg;  // Metastability catcher, read by s2 only
  logic [W-1:0] s2_reg;  // Second stage
  logic [W-1:0] s3_reg;  // Third stage
  logic [W-1:0] q_reg;   // Filtered level

  // Shift chain
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
    end
    else
    begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Bit changes only once stages two and three agree
  generate
    for (genvar gi = 0; gi < W; gi++)
    begin : g_bit
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          q_reg[gi] <= RST_VAL[gi];
        else if (s2_reg[gi] == s3_reg[gi])
          q_reg[gi] <= s3_reg[gi];
      end
    end
  endgenerate

  assign q_out = q_reg;

endmodule

// ==== logic/amgp_port.sv ====
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps

// What this block does
// - Mode 1: address outputs, direction reads ones
// - Mode 1 hardware standby: address pins released
// - Mode 2: direction one drives, zero inputs
// - Mode 3: output or pattern per enable
// - Modes 2,3: direction write-only, reads ones
// - Direction cleared by reset, hardware standby; mode1 ones
// - Software standby keeps direction, outputs keep driving
// - Data read: register if output, else pin
// - Data register cleared by reset, hardware standby
// - Pull-up on when enabled and input, in modes 2 and 3 only
// - Mode 1: pull-ups always off
// - Pull-up register cleared by reset, hardware standby
module amgp_port (
  input  wire logic        clock,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Chip state pins
  input  wire logic [1:0]  mode_pins,
  input  wire logic        hw_standby,
  input  wire logic        sw_standby,
  // Internal sources for the shared pins
  input  wire logic [7:0]  addr_out,
  input  wire logic [7:0]  pattern_data,
  input  wire logic [7:0]  pattern_output_enable,
  // Pad side
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe,
  output logic      [7:0]  pullup_on
);

  localparam int unsigned DW = amgp_pkg::DATA_W;

  // Synchronised chip-state and pad levels
  logic [1:0]                mode_raw;     // Mode pins after filter
  logic                      hw_sync;      // Hardware standby after filter
  logic [DW-1:0]             pin_sync;     // Pad levels after filter
  amgp_pkg::amgp_mode_t      mode_sync;    // Decoded mode

  // Software-visible registers
  logic [DW-1:0]             dir_reg;      // port_direction
  logic [DW-1:0]             data_reg;     // port_output_data
  logic [DW-1:0]             pullup_reg;   // port_pullup_enable

  // Bus decode
  logic                      setup_ph;     // First APB cycle
  logic                      access_ph;    // Second APB cycle
  logic                      hit_dir;      // Direction selected
  logic                      hit_data;     // Data selected
  logic                      hit_pullup;   // Pull-up selected
  logic                      hit_any;      // Some register selected
  logic                      wr_en;        // Write takes effect now
  logic [DW-1:0]             rd_next;      // Read value at setup
  logic [31:0]               prdata_reg;   // Held read data
  logic                      err_reg;      // Held unmapped flag

  // Pad drive next values
  amgp_pkg::amgp_role_t      role_w [DW];  // Per-pin function
  logic [DW-1:0]             out_next;     // Next pad data
  logic [DW-1:0]             oe_next;      // Next pad enable
  logic [DW-1:0]             pu_next;      // Next pull-up state
  logic [DW-1:0]             pin_out_reg;  // Registered pad data
  logic [DW-1:0]             pin_oe_reg;   // Registered pad enable
  logic [DW-1:0]             pu_reg;       // Registered pull-up

  // Byte-address match for one register index
  function automatic logic amgp_hit(input logic [17:0] addr, input logic [15:0] idx);
    amgp_hit = (addr == {idx, 2'b00});
  endfunction

  // Pin function from mode, direction bit and pattern enable
  function automatic amgp_pkg::amgp_role_t amgp_role(
    input amgp_pkg::amgp_mode_t md,
    input logic                 dir_bit,
    input logic                 pat_bit
  );
    amgp_role = amgp_pkg::ROLE_IN;
    case (md)
      amgp_pkg::MODE_1:
        amgp_role = amgp_pkg::ROLE_ADDR;
      amgp_pkg::MODE_2:
        if (dir_bit)
          amgp_role = pat_bit ? amgp_pkg::ROLE_PAT : amgp_pkg::ROLE_ADDR;
      amgp_pkg::MODE_3:
        if (dir_bit)
          amgp_role = pat_bit ? amgp_pkg::ROLE_PAT : amgp_pkg::ROLE_GPO;
      default:
        amgp_role = amgp_pkg::ROLE_IN;  // Undecoded mode keeps pins passive
    endcase
  endfunction

  // Mode and standby come from pins: filter them first
  amgp_sync #(
    .W       (3),
    .RST_VAL (3'h0)
  ) u_ctl_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d_in  ({hw_standby, mode_pins}),
    .q_out ({hw_sync, mode_raw})
  );

  // Pad levels are asynchronous to the bus clock
  amgp_sync #(
    .W       (DW),
    .RST_VAL (amgp_pkg::PIN_IDLE)
  ) u_pin_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d_in  (pin_in),
    .q_out (pin_sync)
  );

  assign mode_sync = amgp_pkg::amgp_mode_t'(mode_raw);

  // APB phases and address decode
  assign setup_ph   = psel && !penable;
  assign access_ph  = psel && penable;
  assign hit_dir    = amgp_hit(paddr, amgp_pkg::IDX_DIR);
  assign hit_data   = amgp_hit(paddr, amgp_pkg::IDX_DATA);
  assign hit_pullup = amgp_hit(paddr, amgp_pkg::IDX_PULLUP);
  assign hit_any    = hit_dir || hit_data || hit_pullup;
  assign wr_en      = access_ph && pwrite;

  // Zero wait states: every access completes in its first access cycle
  assign pready  = access_ph;
  assign pslverr = access_ph && err_reg;
  assign prdata  = prdata_reg;

  // Read mux, evaluated at setup so the answer comes from a flop
  always_comb
  begin
    rd_next = amgp_pkg::RST_DATA;
    if (hit_dir)
      rd_next = amgp_pkg::DIR_READ;
    else if (hit_data)
      rd_next = (dir_reg & data_reg) | (~dir_reg & pin_sync);
    else if (hit_pullup)
      rd_next = pullup_reg;
  end

  // Capture read data and unmapped flag in the setup cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_reg <= 32'h00000000;
      err_reg    <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_reg <= pwrite ? 32'h00000000 : {amgp_pkg::RD_PAD, rd_next};
      err_reg    <= !hit_any;
    end
  end

  // Direction register; mode 1 pins it high and drops writes
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      dir_reg <= amgp_pkg::RST_DIR;
    else if (mode_sync == amgp_pkg::MODE_1)
      dir_reg <= amgp_pkg::DIR_MODE1;
    else if (hw_sync)
      dir_reg <= amgp_pkg::RST_DIR;
    // Software standby is not a case here, so contents persist
    else if (wr_en && hit_dir)
      dir_reg <= pwdata[DW-1:0];
  end

  // Output data register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      data_reg <= amgp_pkg::RST_DATA;
    else if (hw_sync)
      data_reg <= amgp_pkg::RST_DATA;
    else if (wr_en && hit_data)
      data_reg <= pwdata[DW-1:0];
  end

  // Pull-up control register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pullup_reg <= amgp_pkg::RST_PULLUP;
    else if (hw_sync)
      pullup_reg <= amgp_pkg::RST_PULLUP;
    else if (wr_en && hit_pullup)
      pullup_reg <= pwdata[DW-1:0];
  end

  // Per-pin function, drive and pull-up
  generate
    for (genvar gi = 0; gi < DW; gi++)
    begin : g_pin
      assign role_w[gi] = amgp_role(mode_sync, dir_reg[gi], pattern_output_enable[gi]);

      // Source selection by role
      always_comb
      begin
        case (role_w[gi])
          amgp_pkg::ROLE_ADDR: out_next[gi] = addr_out[gi];
          amgp_pkg::ROLE_PAT:  out_next[gi] = pattern_data[gi];
          amgp_pkg::ROLE_GPO:  out_next[gi] = data_reg[gi];
          default:             out_next[gi] = 1'b0;
        endcase
      end

      // Hardware standby floats every driver
      assign oe_next[gi] = (role_w[gi] != amgp_pkg::ROLE_IN) && !hw_sync;

      // Pull-up only in modes 2 and 3, input pins, not in hardware standby
      assign pu_next[gi] = (mode_sync == amgp_pkg::MODE_2 || mode_sync == amgp_pkg::MODE_3)
                           && !hw_sync && pullup_reg[gi] && !dir_reg[gi];
    end
  endgenerate

  // Pad outputs from flops; one cycle behind the selected source
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out_reg <= amgp_pkg::PIN_IDLE;
      pin_oe_reg  <= amgp_pkg::PIN_IDLE;
      pu_reg      <= amgp_pkg::PIN_IDLE;
    end
    else
    begin
      pin_out_reg <= out_next;
      pin_oe_reg  <= oe_next;
      pu_reg      <= pu_next;
    end
  end

  assign pin_out   = pin_out_reg;
  assign pin_oe    = pin_oe_reg;
  assign pullup_on = pu_reg;

  // Mode helpers for the checks below
  logic is_m1;
  logic is_m2;
  logic is_m3;
  assign is_m1 = (mode_sync == amgp_pkg::MODE_1);
  assign is_m2 = (mode_sync == amgp_pkg::MODE_2);
  assign is_m3 = (mode_sync == amgp_pkg::MODE_3);

  // Read transfer to the direction register
  sequence s_dir_read;
    (setup_ph && !pwrite && hit_dir) ##1 access_ph;
  endsequence

  // Read transfer to the data register
  sequence s_data_read;
    (setup_ph && !pwrite && hit_data) ##1 access_ph;
  endsequence

  a_m1_dir_ones: assert property (@(posedge clock) disable iff (!rst_n)
    is_m1 |=> dir_reg == amgp_pkg::DIR_MODE1)
    else $error("mode 1 direction not all ones");

  a_m1_addr_drive: assert property (@(posedge clock) disable iff (!rst_n)
    (is_m1 && !hw_sync) |=> (pin_oe == 8'hFF) && (pin_out == $past(addr_out)))
    else $error("mode 1 pins not driving address");

  a_m1_standby_float: assert property (@(posedge clock) disable iff (!rst_n)
    (is_m1 && hw_sync) |=> pin_oe == 8'h00)
    else $error("address pins driven in hardware standby");

  a_m2_dir_drive: assert property (@(posedge clock) disable iff (!rst_n)
    (is_m2 && !hw_sync) |=> pin_oe == $past(dir_reg))
    else $error("mode 2 enables differ from direction");

  a_m3_gpo_value: assert property (@(posedge clock) disable iff (!rst_n)
    (is_m3 && !hw_sync) |=>
      (pin_out & $past(dir_reg & ~pattern_output_enable))
      == $past(data_reg & dir_reg & ~pattern_output_enable))
    else $error("mode 3 general output wrong");

  a_m3_pat_value: assert property (@(posedge clock) disable iff (!rst_n)
    (is_m3 && !hw_sync) |=>
      (pin_out & $past(dir_reg & pattern_output_enable))
      == $past(pattern_data & dir_reg & pattern_output_enable))
    else $error("mode 3 pattern output wrong");

  a_dir_read_ones: assert property (@(posedge clock) disable iff (!rst_n)
    s_dir_read |-> prdata == 32'h000000FF && !pslverr)
    else $error("direction read not all ones");

  a_hw_dir_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (hw_sync && !is_m1) |=> dir_reg == 8'h00)
    else $error("direction not cleared in standby");

  a_sw_dir_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (sw_standby && !hw_sync && !is_m1 && !wr_en) |=> dir_reg == $past(dir_reg))
    else $error("direction changed in software standby");

  a_data_read_mux: assert property (@(posedge clock) disable iff (!rst_n)
    s_data_read |-> prdata[7:0] == ($past(dir_reg & data_reg) | $past(~dir_reg & pin_sync)))
    else $error("data read mux wrong");

  a_hw_data_clear: assert property (@(posedge clock) disable iff (!rst_n)
    hw_sync |=> data_reg == 8'h00 && pullup_reg == 8'h00)
    else $error("data or pull-up not cleared in standby");

  a_pullup_gate: assert property (@(posedge clock) disable iff (!rst_n)
    ((is_m2 || is_m3) && !hw_sync) |=> pullup_on == $past(pullup_reg & ~dir_reg))
    else $error("pull-up gating wrong");

  a_m1_no_pullup: assert property (@(posedge clock) disable iff (!rst_n)
    is_m1 |=> pullup_on == 8'h00)
    else $error("pull-up on in mode 1");

  a_sw_pullup_keep: assert property (@(posedge clock) disable iff (!rst_n)
    (sw_standby && !hw_sync && !wr_en) |=> $stable(pullup_reg) && $stable(data_reg))
    else $error("registers changed in software standby");

  // Hardware standby floats every pin in every mode
  a_hw_all_float: assert property (@(posedge clock) disable iff (!rst_n)
    hw_sync |=> pin_oe == 8'h00)
    else $error("pins driven in hardware standby");

  // Mode 2 output pins carry pattern or address by enable
  a_m2_src_select: assert property (@(posedge clock) disable iff (!rst_n)
    (is_m2 && !hw_sync) |=>
      (pin_out & $past(dir_reg))
      == $past(((pattern_data & pattern_output_enable) | (addr_out & ~pattern_output_enable)) & dir_reg))
    else $error("mode 2 output source wrong");

  // A data write outside hardware standby lands whole
  a_data_wr_lands: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_en && hit_data && !hw_sync) |=> data_reg == $past(pwdata[7:0]))
    else $error("data write lost");

  // A pull-up write outside hardware standby lands whole
  a_pu_wr_lands: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_en && hit_pullup && !hw_sync) |=> pullup_reg == $past(pwdata[7:0]))
    else $error("pull-up write lost");

endmodule

// ==== verification/amgp_pad_model.sv ====
`timescale 1ns/1ps

// Pads plus an outside driver; a float wanders so it never looks like a stable value
module amgp_pad_model (
  input  wire logic       clock,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_on,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pin_in
);
  logic [7:0] wander_reg = 8'h00; // Changes every cycle

  // Float pattern for undriven, unpulled pins
  always @(posedge clock)
  begin
    wander_reg <= wander_reg + 8'h35;
  end

  // Chip drive wins, then outside drive, then pull-up, else float
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) |
                  (~pin_oe & ~ext_en & (pullup_on | wander_reg));
endmodule

// ==== verification/amgp_tb.sv ====
`timescale 1ns/1ps

module testbench;
  localparam logic [17:0] A_PU = {amgp_pkg::IDX_PULLUP, 2'b00}; // Pull-up enable
  localparam logic [17:0] A_DR = {amgp_pkg::IDX_DIR, 2'b00};    // Direction
  localparam logic [17:0] A_DT = {amgp_pkg::IDX_DATA, 2'b00};   // Output data
  localparam logic [31:0] FF32 = 32'h000000FF;                   // Direction readback
  logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, hw_standby, sw_standby, er;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  mode_pins;
  logic [7:0]  addr_out, pattern_data, pattern_output_enable, pin_in, pin_out, pin_oe, pullup_on;
  logic [7:0]  ext_val, ext_en;
  int          bad_count, tests_run;

  amgp_port uut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_pins(mode_pins), .hw_standby(hw_standby), .sw_standby(sw_standby), .addr_out(addr_out),
    .pattern_data(pattern_data), .pattern_output_enable(pattern_output_enable), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on));
  amgp_pad_model pads (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
    .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  // Clock, 20 ns period
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Pad-side compare, widened on purpose
  task automatic pchk(input string nm, input logic [7:0] e, input logic [7:0] g);
    chk(nm, {24'h000000, e}, {24'h000000, g});
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] wd);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1);
    chk("wait states", 32'h00000001, n);  // Zero wait states; a hang is left to the watchdog
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [17:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  // Lets synchronisers and pin registers catch up
  task automatic settle();
    repeat (8) @(posedge clock);
    #1;
  endtask

  task automatic t_reset();
    ext_en <= 8'hFF;
    ext_val <= 8'h5A;
    settle();
    pchk("oe after reset", 8'h00, pin_oe);
    pchk("pull after reset", 8'h00, pullup_on);
    rdchk("pullup reg", A_PU, 32'h0);
    rdchk("dir read", A_DR, FF32);
    rdchk("data pins", A_DT, 32'h5A);
    $display("test reset done");
  endtask

  task automatic t_mode2();
    pattern_output_enable <= 8'h05;
    addr_out <= 8'h3C;
    pattern_data <= 8'hC3;
    ext_en <= 8'hF0;
    ext_val <= 8'hA0;
    apb(1'b1, A_DR, 32'h0F);
    apb(1'b1, A_DT, 32'h99);
    apb(1'b1, A_PU, 32'hFF);
    settle();
    pchk("oe mode2", 8'h0F, pin_oe);
    pchk("out mode2", 8'h09, pin_out & 8'h0F);
    pchk("pull mode2", 8'hF0, pullup_on);
    rdchk("data mixed", A_DT, 32'hA9);
    rdchk("pullup reg", A_PU, 32'hFF);
    rdchk("dir read", A_DR, FF32);
    $display("test mode2 done");
  endtask

  task automatic t_mode3();
    mode_pins <= amgp_pkg::MODE_3;
    pattern_output_enable <= 8'h03;
    settle();
    pchk("oe mode3", 8'h0F, pin_oe);
    pchk("out mode3", 8'h0B, pin_out & 8'h0F);
    $display("test mode3 done");
  endtask

  task automatic t_soft();
    @(posedge clock);
    sw_standby <= 1'b1;
    settle();
    pchk("oe soft", 8'h0F, pin_oe);
    pchk("pull soft", 8'hF0, pullup_on);
    rdchk("data soft", A_DT, 32'hA9);
    sw_standby <= 1'b0;
    $display("test soft standby done");
  endtask

  task automatic t_hard();
    hw_standby <= 1'b1;
    settle();
    pchk("oe hard", 8'h00, pin_oe);
    pchk("pull hard", 8'h00, pullup_on);
    @(posedge clock);
    hw_standby <= 1'b0;
    settle();
    pchk("oe after hard", 8'h00, pin_oe);
    rdchk("pullup cleared", A_PU, 32'h0);
    apb(1'b1, A_DR, 32'hFF);
    rdchk("data cleared", A_DT, 32'h0);
    apb(1'b1, 18'h00004, 32'hFF);
    chk("unmapped err", 32'h1, {31'h0, er});
    rdchk("unmapped read", 18'h00004, 32'h0);
    $display("test hard standby done");
  endtask

  task automatic t_mode1();
    apb(1'b1, A_DR, 32'h00);
    apb(1'b1, A_PU, 32'hFF);
    mode_pins <= amgp_pkg::MODE_1;
    settle();
    apb(1'b1, A_DR, 32'h00);
    settle();
    pchk("oe mode1", 8'hFF, pin_oe);
    pchk("out mode1", 8'h3C, pin_out);
    pchk("pull mode1", 8'h00, pullup_on);
    rdchk("dir mode1", A_DR, FF32);
    @(posedge clock);
    hw_standby <= 1'b1;
    settle();
    pchk("oe mode1 hard", 8'h00, pin_oe);
    @(posedge clock);
    hw_standby <= 1'b0;
    $display("test mode1 done");
  endtask

  // Undecoded mode, then a second reset in mid-run
  task automatic t_rerst();
    mode_pins <= amgp_pkg::MODE_2;
    settle();
    apb(1'b1, A_DR, 32'h0000000F);
    apb(1'b1, A_PU, 32'h00000033);
    apb(1'b1, A_DT, 32'h0000005A);
    settle();
    pchk("pull rerun", 8'h30, pullup_on);
    @(posedge clock);
    mode_pins <= amgp_pkg::MODE_NONE;
    settle();
    pchk("oe no mode", 8'h00, pin_oe);
    pchk("pull no mode", 8'h00, pullup_on);
    @(posedge clock);
    mode_pins <= amgp_pkg::MODE_2;
    rst_n <= 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    pchk("oe early rerun", 8'h00, pin_oe);
    pchk("pull early rerun", 8'h00, pullup_on);
    settle();
    pchk("oe rerun", 8'h00, pin_oe);
    rdchk("pullup rerun", A_PU, 32'h0);
    apb(1'b1, A_DR, 32'h000000FF);
    rdchk("data rerun", A_DT, 32'h0);
    $display("test mid-run reset done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog well beyond the sequence length
  initial
  begin
    repeat (20000) @(posedge clock);
    bad_count++;
    print_verdict();
  end

  // Main sequence
  initial
  begin
    bad_count = 0;
    tests_run = 0;
    rst_n = 1'b0;
    {psel, penable, pwrite, hw_standby, sw_standby} = 5'h00;
    paddr = 18'h00000;
    pwdata = 32'h0;
    mode_pins = amgp_pkg::MODE_2;
    {addr_out, pattern_data, pattern_output_enable, ext_val, ext_en} = 40'h0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_mode2();
    t_mode3();
    t_soft();
    t_hard();
    t_mode1();
    t_rerst();
    print_verdict();
  end
endmodule
